// ==== core/bsp_defines.svh ====
// Constants for the burst stop and precharge sequencer
`ifndef BSP_DEFINES_SVH
`define BSP_DEFINES_SVH

`define BSP_CA_W        10
`define BSP_DQ_W        16
`define BSP_DM_W        2
`define BSP_BANKS       8
`define BSP_BANK_W      3
`define BSP_PIN_W       29
`define BSP_TICK_W      8
`define BSP_GRP_W       64
`define BSP_BE_W        8
`define BSP_WBUF_W      75

// Positions inside the synchronised pin vector
`define BSP_P_CS        28
`define BSP_P_CA_HI     27
`define BSP_P_CA_LO     18
`define BSP_P_DQ_HI     17
`define BSP_P_DQ_LO     2
`define BSP_P_DM_HI     1
`define BSP_P_DM_LO     0

// Command/address field positions
`define BSP_CA_OP0      0
`define BSP_CA_OP1      1
`define BSP_CA_OP2      2
`define BSP_CA_OP3      3
`define BSP_CA_AP       0
`define BSP_CA_AB       4
`define BSP_CA_BA_LO    7
`define BSP_CA_BA_HI    9

// Counts and fixed values
`define BSP_ONE8        8'h01
`define BSP_ZERO8       8'h00
`define BSP_AGE_MAX     8'hff
`define BSP_BL_HALF_MIN 8'h02
`define BSP_TRTP_BASE   4'h2
`define BSP_LAST_BEAT   2'h3
`define BSP_BEAT_ONE    2'h1
`define BSP_ALL_BANKS   8'hff
`define BSP_BANK0       8'h01
`define BSP_BA_LOW_KEEP 2'h3

`endif

// ==== core/bsp_pkg.sv ====
// Types shared by the burst stop and precharge sequencer
`default_nettype none
package bsp_pkg;
    typedef enum logic [1:0] {bsp_k_none, bsp_k_rd, bsp_k_wr} bsp_kind_t;
endpackage
`default_nettype wire

// ==== core/bsp_wbuf.sv ====
// Two-entry buffer between write prefetch assembly and the array port
`timescale 1ns/10ps
`default_nettype none
module bsp_wbuf #(
    parameter int W = 8
) (
    input  wire logic         clk_in,
    input  wire logic         arst_n_in,
    input  wire logic         in_valid_in,
    input  wire logic [W-1:0] in_data_in,
    output var  logic         in_ready_out,
    output var  logic         out_valid_out,
    output var  logic [W-1:0] out_data_out,
    input  wire logic         out_ready_in
);
    logic [W-1:0] d1;
    logic         v1;
    logic [W-1:0] next_d0;
    logic [W-1:0] next_d1;
    logic         next_v0;
    logic         next_v1;

    // Head entry always sits in slot 0 so the outputs are flops
    always_comb begin
        next_d0 = out_data_out;
        next_d1 = d1;
        next_v0 = out_valid_out;
        next_v1 = v1;
        if (out_valid_out && out_ready_in) begin
            next_d0 = d1;
            next_v0 = v1;
            next_v1 = 1'b0;
        end
        if (in_valid_in && !v1) begin
            if (!next_v0) begin
                next_d0 = in_data_in;
                next_v0 = 1'b1;
            end else begin
                next_d1 = in_data_in;
                next_v1 = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            out_data_out  <= '0;
            d1            <= '0;
            out_valid_out <= 1'b0;
            v1            <= 1'b0;
            in_ready_out  <= 1'b0;
        end else begin
            out_data_out  <= next_d0;
            d1            <= next_d1;
            out_valid_out <= next_v0;
            v1            <= next_v1;
            in_ready_out  <= !next_v1;
        end
    end
endmodule // bsp_wbuf
`default_nettype wire

// ==== core/bsp_core.sv ====
// Burst stop, write interrupt and precharge sequencing on the device side
`timescale 1ns/10ps
`default_nettype none
`include "bsp_defines.svh"

// Function
// - Interrupted write length is twice the cycles between the two WRITEs.
// - BST decodes as chip select low, CA0 CA1 high, CA2 CA3 low.
// - Truncated burst length is twice the cycles from access to BST.
// - BST hits the latest access; data stops RL or WL cycles later.
// - Each byte lane mask, timed like data, leaves that byte unwritten.
// - PRECHARGE decodes as chip select low, CA0 CA1 CA3 high, CA2 low.
// - All-bank flag closes all; else bank bits pick one, top bit ignored if 4-bank.
// - Writes go to the array in complete groups of four beats.
// - Auto-precharge bit low leaves the bank open after the burst.
// - Auto-precharge bit high closes the bank at the earliest legal moment; one is held at a time, and a later access with the bit high replaces it.
// - Auto-precharge bit is CA0 on the falling edge of the access.
// - Read auto precharge starts at max(BL/2, BL/2-2+RU(tRTP/tCK)).
// - Write auto precharge starts WL+BL/2+1+tWR cycles after the WRITE.
module bsp_core import bsp_pkg::*; (
    input  wire logic                      clk_in,
    input  wire logic                      arst_n_in,
    input  wire logic                      ck_in,
    input  wire logic                      cs_n_in,
    input  wire logic [`BSP_CA_W-1:0]      ca_in,
    input  wire logic [`BSP_DQ_W-1:0]      dq_in,
    input  wire logic [`BSP_DM_W-1:0]      dm_in,
    input  wire logic [1:0]                bl_cfg_in,
    input  wire logic [3:0]                rl_cfg_in,
    input  wire logic [3:0]                wl_cfg_in,
    input  wire logic [3:0]                twr_cfg_in,
    input  wire logic [3:0]                trtp_cfg_in,
    input  wire logic                      eight_bank_in,
    input  wire logic                      arr_wr_ready_in,
    output var  logic [`BSP_BANKS-1:0]     bank_open_out,
    output var  logic                      prech_out,
    output var  logic [`BSP_BANKS-1:0]     prech_mask_out,
    output var  logic                      rd_burst_out,
    output var  logic                      wr_burst_out,
    output var  logic                      cut_out,
    output var  logic [`BSP_TICK_W-1:0]    cut_bl_out,
    output var  logic                      arr_wr_valid_out,
    output var  logic [`BSP_GRP_W-1:0]     arr_wr_data_out,
    output var  logic [`BSP_BE_W-1:0]      arr_wr_be_out,
    output var  logic [`BSP_BANK_W-1:0]    arr_wr_bank_out,
    output var  logic                      wr_room_out,
    output var  logic                      wr_ovf_out
);
    // ****************
    // Pin synchronisers
    // ****************
    logic                     ck_s1, ck_s2, ck_s3;
    logic [`BSP_PIN_W-1:0]    pin_s1, pin_s2, pin_s3;

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            ck_s1  <= 1'b0;
            ck_s2  <= 1'b0;
            ck_s3  <= 1'b0;
            pin_s1 <= '0;
            pin_s2 <= '0;
            pin_s3 <= '0;
        end else begin
            ck_s1  <= ck_in;
            ck_s2  <= ck_s1;
            ck_s3  <= ck_s2;
            pin_s1 <= {cs_n_in, ca_in, dq_in, dm_in};
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
        end
    end

    logic                     cs_n;
    logic [`BSP_CA_W-1:0]     ca;
    logic [`BSP_DQ_W-1:0]     dq;
    logic [`BSP_DM_W-1:0]     dm;
    logic                     is_rw, is_rd, is_wr, is_bst, is_pre, is_act;
    logic [`BSP_BANK_W-1:0]   bank;
    logic [`BSP_TICK_W-1:0]   bl_half, rl8, wl8, twr8, trtp_x;

    assign cs_n    = pin_s3[`BSP_P_CS];
    assign ca      = pin_s3[`BSP_P_CA_HI:`BSP_P_CA_LO];
    assign dq      = pin_s3[`BSP_P_DQ_HI:`BSP_P_DQ_LO];
    assign dm      = pin_s3[`BSP_P_DM_HI:`BSP_P_DM_LO];
    assign is_rw   = ca[`BSP_CA_OP0] && !ca[`BSP_CA_OP1];
    assign is_rd   = is_rw && ca[`BSP_CA_OP2];
    assign is_wr   = is_rw && !ca[`BSP_CA_OP2];
    assign is_bst  = ca[`BSP_CA_OP0] && ca[`BSP_CA_OP1] && !ca[`BSP_CA_OP2]
                     && !ca[`BSP_CA_OP3];
    assign is_pre  = ca[`BSP_CA_OP0] && ca[`BSP_CA_OP1] && !ca[`BSP_CA_OP2]
                     && ca[`BSP_CA_OP3];
    assign is_act  = !ca[`BSP_CA_OP0] && !ca[`BSP_CA_OP1];
    // Four-bank parts drop the top bank bit
    assign bank    = ca[`BSP_CA_BA_HI:`BSP_CA_BA_LO]
                     & {eight_bank_in, `BSP_BA_LOW_KEEP};
    assign bl_half = `BSP_BL_HALF_MIN << bl_cfg_in;
    assign rl8     = {4'h0, rl_cfg_in};
    assign wl8     = {4'h0, wl_cfg_in};
    assign twr8    = {4'h0, twr_cfg_in};
    assign trtp_x  = (trtp_cfg_in > `BSP_TRTP_BASE) ?
                     {4'h0, trtp_cfg_in - `BSP_TRTP_BASE} : `BSP_ZERO8;

    // ****************
    // Command sequencing
    // ****************
    logic                     ck_lvl, rise, fall, agree;
    logic [`BSP_TICK_W-1:0]   tick, age, eff_half, ap_tick, a1, tick_n;
    logic [`BSP_TICK_W-1:0]   rd_start, rd_len, wr_start, wr_len;
    bsp_kind_t                kind, next_kind;
    logic                     bst_done, cmd_pend, cmd_wr, ap_pend;
    logic [`BSP_BANK_W-1:0]   cmd_bank, ap_bank, wr_bank;
    logic                     next_ck_lvl, next_bst_done, next_cmd_pend, next_cmd_wr;
    logic                     next_ap_pend, next_prech, next_rd_burst, next_wr_burst;
    logic                     next_cut;
    logic [`BSP_TICK_W-1:0]   next_tick, next_age, next_eff_half, next_ap_tick;
    logic [`BSP_TICK_W-1:0]   next_rd_start, next_rd_len, next_wr_start, next_wr_len;
    logic [`BSP_TICK_W-1:0]   next_cut_bl;
    logic [`BSP_BANK_W-1:0]   next_cmd_bank, next_ap_bank, next_wr_bank;
    logic [`BSP_BANKS-1:0]    next_bank_open, next_prech_mask;

    always_comb begin
        logic [`BSP_BANKS-1:0] close_mask;
        logic [`BSP_BANKS-1:0] open_mask;
        close_mask      = '0;
        open_mask       = '0;
        agree           = (ck_s2 == ck_s3);
        rise            = agree && ck_s3 && !ck_lvl;
        fall            = agree && !ck_s3 && ck_lvl;
        tick_n          = tick + `BSP_ONE8;
        a1              = (age == `BSP_AGE_MAX) ? age : age + `BSP_ONE8;
        next_ck_lvl     = agree ? ck_s3 : ck_lvl;
        next_tick       = tick;
        next_age        = age;
        next_kind       = kind;
        next_bst_done   = bst_done;
        next_eff_half   = eff_half;
        next_cmd_pend   = cmd_pend;
        next_cmd_wr     = cmd_wr;
        next_cmd_bank   = cmd_bank;
        next_ap_pend    = ap_pend;
        next_ap_tick    = ap_tick;
        next_ap_bank    = ap_bank;
        next_rd_start   = rd_start;
        next_rd_len     = rd_len;
        next_wr_start   = wr_start;
        next_wr_len     = wr_len;
        next_wr_bank    = wr_bank;
        next_bank_open  = bank_open_out;
        next_prech      = 1'b0;
        next_prech_mask = prech_mask_out;
        next_rd_burst   = rd_burst_out;
        next_wr_burst   = wr_burst_out;
        next_cut        = 1'b0;
        next_cut_bl     = cut_bl_out;
        if (rise) begin
            next_tick = tick_n;
            next_age  = a1;
            if (ap_pend && tick_n == ap_tick) begin
                close_mask   = `BSP_BANK0 << ap_bank;
                next_ap_pend = 1'b0;
            end
            if (!cs_n && is_rw) begin
                // Same-kind command before the old burst ends interrupts it
                if (kind != bsp_k_none && is_wr == (kind == bsp_k_wr) && a1 < eff_half) begin
                    next_cut    = 1'b1;
                    next_cut_bl = a1 << 1;
                end
                if (is_rd) begin
                    if (!(kind == bsp_k_rd && a1 < eff_half)) begin
                        next_rd_start = tick_n + rl8;
                    end
                    next_rd_len = tick_n + rl8 + bl_half - next_rd_start;
                    next_kind   = bsp_k_rd;
                end else begin
                    if (!(kind == bsp_k_wr && a1 < eff_half)) begin
                        next_wr_start = tick_n + wl8;
                    end
                    next_wr_len  = tick_n + wl8 + bl_half - next_wr_start;
                    next_wr_bank = bank;
                    next_kind    = bsp_k_wr;
                end
                next_age      = `BSP_ZERO8;
                next_eff_half = bl_half;
                next_bst_done = 1'b0;
                next_cmd_pend = 1'b1;
                next_cmd_wr   = is_wr;
                next_cmd_bank = bank;
            end else if (!cs_n && is_bst && kind != bsp_k_none && !bst_done) begin
                // Only the latest access is cut; data stops one latency later
                next_bst_done = 1'b1;
                next_cut      = 1'b1;
                next_cut_bl   = a1 << 1;
                next_eff_half = a1;
                if (kind == bsp_k_rd) begin
                    next_rd_len = tick_n + rl8 - rd_start;
                end else begin
                    next_wr_len = tick_n + wl8 - wr_start;
                end
            end else if (!cs_n && is_pre) begin
                close_mask = close_mask
                             | (ca[`BSP_CA_AB] ? `BSP_ALL_BANKS : (`BSP_BANK0 << bank));
            end else if (!cs_n && is_act) begin
                open_mask = `BSP_BANK0 << bank;
            end
            next_bank_open = (bank_open_out & ~close_mask) | open_mask;
            next_prech     = |close_mask;
            if (|close_mask) begin
                next_prech_mask = close_mask;
            end
            next_rd_burst = (tick_n - next_rd_start) < next_rd_len;
            next_wr_burst = (tick_n - next_wr_start) < next_wr_len;
        end
        if (fall && cmd_pend) begin
            next_cmd_pend = 1'b0;
            if (ca[`BSP_CA_AP]) begin
                next_ap_pend = 1'b1;
                next_ap_bank = cmd_bank;
                if (cmd_wr) begin
                    next_ap_tick = tick + wl8 + bl_half + `BSP_ONE8 + twr8;
                end else begin
                    next_ap_tick = tick + bl_half + trtp_x;
                end
            end
        end
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            ck_lvl         <= 1'b0;
            tick           <= '0;
            age            <= '0;
            kind           <= bsp_k_none;
            bst_done       <= 1'b0;
            eff_half       <= '0;
            cmd_pend       <= 1'b0;
            cmd_wr         <= 1'b0;
            cmd_bank       <= '0;
            ap_pend        <= 1'b0;
            ap_tick        <= '0;
            ap_bank        <= '0;
            rd_start       <= '0;
            rd_len         <= '0;
            wr_start       <= '0;
            wr_len         <= '0;
            wr_bank        <= '0;
            bank_open_out  <= '0;
            prech_out      <= 1'b0;
            prech_mask_out <= '0;
            rd_burst_out   <= 1'b0;
            wr_burst_out   <= 1'b0;
            cut_out        <= 1'b0;
            cut_bl_out     <= '0;
        end else begin
            ck_lvl         <= next_ck_lvl;
            tick           <= next_tick;
            age            <= next_age;
            kind           <= next_kind;
            bst_done       <= next_bst_done;
            eff_half       <= next_eff_half;
            cmd_pend       <= next_cmd_pend;
            cmd_wr         <= next_cmd_wr;
            cmd_bank       <= next_cmd_bank;
            ap_pend        <= next_ap_pend;
            ap_tick        <= next_ap_tick;
            ap_bank        <= next_ap_bank;
            rd_start       <= next_rd_start;
            rd_len         <= next_rd_len;
            wr_start       <= next_wr_start;
            wr_len         <= next_wr_len;
            wr_bank        <= next_wr_bank;
            bank_open_out  <= next_bank_open;
            prech_out      <= next_prech;
            prech_mask_out <= next_prech_mask;
            rd_burst_out   <= next_rd_burst;
            wr_burst_out   <= next_wr_burst;
            cut_out        <= next_cut;
            cut_bl_out     <= next_cut_bl;
        end
    end

    // ****************
    // Write beat assembly
    // ****************
    logic [1:0]               beat_cnt, next_beat_cnt;
    logic [`BSP_GRP_W-1:0]    grp_data, next_grp_data;
    logic [`BSP_BE_W-1:0]     grp_be, next_grp_be;
    logic                     push_v, next_push_v, next_ovf, buf_ready, beat;
    logic [`BSP_WBUF_W-1:0]   push_pay, next_push_pay, pop_pay;

    always_comb begin
        beat          = (rise && next_wr_burst) || (fall && wr_burst_out);
        next_push_v   = push_v && !buf_ready;
        next_push_pay = push_pay;
        next_ovf      = wr_ovf_out;
        next_beat_cnt = beat_cnt;
        next_grp_data = grp_data;
        next_grp_be   = grp_be;
        if (beat) begin
            next_grp_data = {dq, grp_data[`BSP_GRP_W-1:`BSP_DQ_W]};
            next_grp_be   = {~dm, grp_be[`BSP_BE_W-1:`BSP_DM_W]};
            next_beat_cnt = beat_cnt + `BSP_BEAT_ONE;
            if (beat_cnt == `BSP_LAST_BEAT) begin
                // Only whole four-beat groups reach the array
                if (next_push_v) begin
                    next_ovf = 1'b1;
                end
                next_push_v   = 1'b1;
                next_push_pay = {wr_bank, next_grp_be, next_grp_data};
            end
        end else if (rise && !next_wr_burst) begin
            next_beat_cnt = '0;
        end
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            beat_cnt   <= '0;
            grp_data   <= '0;
            grp_be     <= '0;
            push_v     <= 1'b0;
            push_pay   <= '0;
            wr_ovf_out <= 1'b0;
        end else begin
            beat_cnt   <= next_beat_cnt;
            grp_data   <= next_grp_data;
            grp_be     <= next_grp_be;
            push_v     <= next_push_v;
            push_pay   <= next_push_pay;
            wr_ovf_out <= next_ovf;
        end
    end

    bsp_wbuf #(.W(`BSP_WBUF_W)) u_wbuf (
        .clk_in        (clk_in),
        .arst_n_in     (arst_n_in),
        .in_valid_in   (push_v),
        .in_data_in    (push_pay),
        .in_ready_out  (buf_ready),
        .out_valid_out (arr_wr_valid_out),
        .out_data_out  (pop_pay),
        .out_ready_in  (arr_wr_ready_in)
    );

    assign wr_room_out     = buf_ready;
    assign arr_wr_data_out = pop_pay[`BSP_GRP_W-1:0];
    assign arr_wr_be_out   = pop_pay[`BSP_GRP_W+`BSP_BE_W-1:`BSP_GRP_W];
    assign arr_wr_bank_out = pop_pay[`BSP_WBUF_W-1:`BSP_GRP_W+`BSP_BE_W];

    // ****************
    // Checks
    // ****************
    default clocking @(posedge clk_in); endclocking
    default disable iff (!arst_n_in);

    sequence s_cmd_edge;
        rise && !cs_n;
    endsequence
    sequence s_bst_take;
        s_cmd_edge ##0 (is_bst && kind != bsp_k_none && !bst_done);
    endsequence
    sequence s_ap_req;
        fall && cmd_pend && ca[`BSP_CA_AP];
    endsequence

    a_bst_trunc_len: assert property (s_bst_take |=> cut_out && cut_bl_out == ($past(a1) << 1))
        else $error("BST truncation length wrong");
    a_bst_rd_stop: assert property (s_bst_take ##0 kind == bsp_k_rd
        |=> rd_start + rd_len == $past(tick_n) + rl8)
        else $error("Read burst end not tied to BST");
    a_wr_intr_len: assert property (s_cmd_edge ##0 (is_wr && kind == bsp_k_wr && a1 < eff_half)
        |=> cut_out && cut_bl_out == ($past(a1) << 1))
        else $error("Interrupted write length wrong");
    a_pre_all_close: assert property (s_cmd_edge ##0 (is_pre && ca[`BSP_CA_AB])
        |=> prech_out && prech_mask_out == `BSP_ALL_BANKS && bank_open_out == '0)
        else $error("All-bank precharge did not close all banks");
    a_pre_four_bank: assert property (prech_out && !eight_bank_in
        |-> prech_mask_out[7:4] == '0 || prech_mask_out == `BSP_ALL_BANKS)
        else $error("Four-bank precharge hit upper bank");
    a_ap_off_open: assert property (fall && cmd_pend && !ca[`BSP_CA_AP] && !ap_pend
        |=> !ap_pend)
        else $error("Auto precharge armed with bit low");
    a_ap_rd_time: assert property (s_ap_req ##0 !cmd_wr
        |=> ap_pend && ap_tick == $past(tick) + bl_half + trtp_x)
        else $error("Read auto precharge time wrong");
    a_ap_fire_close: assert property (rise && ap_pend && tick_n == ap_tick && !is_act
        |=> prech_out && !bank_open_out[$past(ap_bank)])
        else $error("Auto precharge did not close bank");
    a_grp_push_full: assert property ($rose(push_v) |-> $past(beat_cnt) == `BSP_LAST_BEAT)
        else $error("Partial prefetch group pushed");
    a_mask_be_map: assert property ($rose(push_v)
        |-> push_pay[`BSP_GRP_W+`BSP_BE_W-1:`BSP_GRP_W+`BSP_BE_W-`BSP_DM_W] == ~$past(dm))
        else $error("Byte enable does not follow mask");
endmodule // bsp_core
`default_nettype wire

// ==== testbench/bsp_ctl.sv ====
// Controller model driving link clock, command lines and write data
`timescale 1ns/10ps
`default_nettype none
module bsp_ctl (
    output var logic        ck_out,
    output var logic        cs_n_out,
    output var logic [9:0]  ca_out,
    output var logic [15:0] dq_out,
    output var logic [1:0]  dm_out
);
    initial {ck_out, cs_n_out, ca_out, dq_out, dm_out} = {2'b01, 28'h0};
    // One link cycle; clock idles low, lines invert once hold ends
    task automatic cyc(input logic cs, input logic [9:0] cr, cf, input logic [15:0] dr, df,
                       input logic [3:0] m);
        {cs_n_out, ca_out, dq_out, dm_out} = {cs, cr, dr, m[1:0]};
        #80 ck_out = 1'b1;
        #80 {cs_n_out, ca_out, dq_out, dm_out} = {1'b1, cf, df, m[3:2]};
        #80 ck_out = 1'b0;
        #40 {ca_out, dq_out, dm_out} = ~{ca_out, dq_out, dm_out};
        #40;
    endtask
endmodule // bsp_ctl
`default_nettype wire

// ==== testbench/testbench.sv ====
// Self-checking bench for the burst stop and precharge sequencer
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic        clk_in = 1'b0, arst_n_in = 1'b0, rdy = 1'b0, eight = 1'b1;
    logic        ck, cs_n, pre, cut, wv;
    logic        rdb, wrb, room, ovf;
    logic [2:0]  wbank;
    logic [1:0]  dm, bl = 2'h2;
    logic [9:0]  ca;
    logic [15:0] dq;
    logic [7:0]  op, pm, cbl, be;
    logic [63:0] wd;
    int          mismatches = 0, compares = 0, cyc_n = 0, npre = 0, ncut = 0;
    always #20 clk_in = ~clk_in;
    always @(posedge clk_in) begin
        {npre, ncut} <= {npre + int'(pre === 1'b1), ncut + int'(cut === 1'b1)};
        cyc_n <= cyc_n + 1;
        if (cyc_n == 1000) summarize();
    end
    bsp_ctl bsp_ctl_i (.ck_out(ck), .cs_n_out(cs_n), .ca_out(ca), .dq_out(dq), .dm_out(dm));
    bsp_core bsp_core_i (.clk_in(clk_in), .arst_n_in(arst_n_in), .ck_in(ck), .cs_n_in(cs_n),
        .ca_in(ca), .dq_in(dq), .dm_in(dm), .bl_cfg_in(bl), .rl_cfg_in(4'h3), .wl_cfg_in(4'h1),
        .twr_cfg_in(4'h2), .trtp_cfg_in(4'h2), .eight_bank_in(eight), .arr_wr_ready_in(rdy),
        .bank_open_out(op), .prech_out(pre), .prech_mask_out(pm), .rd_burst_out(rdb),
        .wr_burst_out(wrb), .cut_out(cut), .cut_bl_out(cbl), .arr_wr_valid_out(wv),
        .arr_wr_data_out(wd), .arr_wr_be_out(be), .arr_wr_bank_out(wbank),
        .wr_room_out(room), .wr_ovf_out(ovf));
    task automatic chk(input logic [79:0] got, exp);
        compares++;
        mismatches += int'(got !== exp);
        if (got !== exp) $display("BAD %0t got %h want %h", $time, got, exp);
    endtask
    // Bit 10 carries the auto-precharge flag
    task automatic cmd(input logic [10:0] c);
        bsp_ctl_i.cyc(1'b0, c[9:0], {9'h0, c[10]}, 16'h0f0f, 16'hf0f0, 4'h0);
    endtask
    task automatic idle(input int n);
        repeat (n) bsp_ctl_i.cyc(1'b1, 10'h000, 10'h000, 16'h1234, 16'hedcb, 4'h0);
    endtask
    task automatic summarize();
        mismatches += int'(cyc_n >= 1000);
        $display("Compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic t_prech();
        cmd(11'h100);
        cmd(11'h280);
        chk(op, 8'h24);
        cmd(11'h01b);
        chk({npre, pm, op}, {32'd1, 16'hff00});
        eight = 1'b0;
        cmd(11'h080);
        cmd(11'h28b);
        chk({npre, pm, op}, {32'd2, 16'h0200});
    endtask
    task automatic t_bst_wr();
        cmd(11'h001);
        bsp_ctl_i.cyc(1'b1, 10'h000, 10'h000, 16'h1100, 16'h3322, 4'h4);
        bsp_ctl_i.cyc(1'b0, 10'h003, 10'h000, 16'h5544, 16'h7766, 4'h0);
        idle(3);
        chk({ncut, cbl}, {32'd1, 8'h04});
        chk({wv, be, wd}, {1'b1, 8'hfb, 64'h7766554433221100});
        rdy = 1'b1;
        idle(2);
        cmd(11'h003);
        chk({ncut, wv}, {32'd1, 1'b0});
    endtask
    task automatic t_rd_ap();
        bl = 2'h0;
        cmd(11'h180);
        cmd(11'h185);
        idle(4);
        chk({npre, op}, {32'd2, 8'h08});
        cmd(11'h585);
        idle(1);
        chk(npre, 2);
        idle(1);
        chk({npre, pm, op}, {32'd3, 16'h0800});
    endtask
    // Read cut by BST, then a write interrupted by a write into a stalled array
    task automatic t_cut_seq();
        bl = 2'h2;
        cmd(11'h100);
        cmd(11'h105);
        idle(1);
        cmd(11'h003);
        idle(1);
        chk({ncut, cbl, rdb}, {32'd2, 8'h04, 1'b1});
        idle(2);
        chk(rdb, 1'b0);
        cmd(11'h10b);
        chk({npre, pm, op}, {32'd4, 16'h0400});
        idle(1);
        rdy = 1'b0;
        cmd(11'h100);
        cmd(11'h101);
        idle(1);
        cmd(11'h101);
        chk({ncut, cbl, wrb}, {32'd3, 8'h04, 1'b1});
        idle(9);
        chk({wv, be, wd}, {9'h1ff, 64'hf0f00f0fedcb1234});
        chk({wbank, room, ovf, wrb}, 6'h12);
        rdy = 1'b1;
        idle(2);
        cmd(11'h10b);
        chk({npre, pm, op, wv, room}, {32'd5, 16'h0400, 2'b01});
    endtask
    initial begin
        #640 arst_n_in = 1'b1;
        #160 t_prech();
        t_bst_wr();
        t_rd_ap();
        t_cut_seq();
        summarize();
    end
endmodule // testbench
`default_nettype wire
